/* hdl/usdc_config.sv */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module usdc_config
    import usdc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // axi4-lite register bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // flags and baud ticks from the rest of the transceiver
    input wire logic tx_buffer_empty_flag,
    input wire logic rx_buffer_full_flag,
    input wire logic baud_rise_tick,
    input wire logic baud_fall_tick,
    input wire logic rx_one_zero_edge,
    // configuration and timing to the transceiver
    output usdc_cfg_t cfg,
    output logic rx_sample_en,
    output logic tx_bit_en,
    output logic rx_realign,
    // dma and interrupt
    output logic tx_dma_req,
    output logic rx_dma_req,
    output logic irq
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic wr_en, rd_en;
    logic [3:0] wr_idx, rd_idx;
    logic [7:0] wr_data, rd_data;

    usdc_axil_slave u_slave (
        .sys_clk(sys_clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_en(rd_en),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    logic [EVT_W-1:0] status_reg, status_next, mask_reg, events;
    logic wr_char_ovs, wr_dma_sample, wr_mask, rd_status;
    logic [4:0] ovs_code_in;
    logic ovs_invalid;

    assign wr_char_ovs = wr_en & (wr_idx == IDX_CHAR_OVS_CTRL);
    assign wr_dma_sample = wr_en & (wr_idx == IDX_DMA_SAMPLE_CTRL);
    assign wr_mask = wr_en & (wr_idx == IDX_EVENT_MASK);
    assign rd_status = rd_en & (rd_idx == IDX_EVENT_STATUS);
    assign ovs_code_in = wr_data[4:0];
    assign ovs_invalid = wr_char_ovs & (ovs_code_in < OVS_MIN_CODE);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg.ten_bit_char_select <= CHAR_OVS_RESET[BIT_TEN_BIT];
            cfg.oversample_ratio <= CHAR_OVS_RESET[4:0];
            cfg.tx_empty_dma_enable <= DMA_SAMPLE_RESET[BIT_TX_DMA_EN];
            cfg.rx_full_dma_enable <= DMA_SAMPLE_RESET[BIT_RX_DMA_EN];
            cfg.dual_edge_sampling <= DMA_SAMPLE_RESET[BIT_DUAL_EDGE];
            cfg.midword_realign_disable <= DMA_SAMPLE_RESET[BIT_REALIGN_DIS];
        end else begin
            if (wr_char_ovs) begin
                cfg.ten_bit_char_select <= wr_data[BIT_TEN_BIT];
                // a ratio below four cannot be sampled, so fall back to sixteen
                cfg.oversample_ratio <= usdc_ovs_fix(ovs_code_in);
            end
            if (wr_dma_sample) begin
                cfg.tx_empty_dma_enable <= wr_data[BIT_TX_DMA_EN];
                cfg.rx_full_dma_enable <= wr_data[BIT_RX_DMA_EN];
                cfg.dual_edge_sampling <= wr_data[BIT_DUAL_EDGE];
                cfg.midword_realign_disable <= wr_data[BIT_REALIGN_DIS];
            end
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [7:0] rd_char_ovs, rd_dma_sample;

    assign rd_char_ovs = {2'b00, cfg.ten_bit_char_select, cfg.oversample_ratio};
    // reserved positions are constant zero, writes to them are dropped
    assign rd_dma_sample = {cfg.tx_empty_dma_enable, 1'b0, cfg.rx_full_dma_enable,
                            3'b000, cfg.dual_edge_sampling, cfg.midword_realign_disable};
    assign rd_data = (rd_idx == IDX_CHAR_OVS_CTRL) ? rd_char_ovs :
                     (rd_idx == IDX_DMA_SAMPLE_CTRL) ? rd_dma_sample :
                     (rd_idx == IDX_EVENT_STATUS) ? {5'b00000, status_reg} :
                     (rd_idx == IDX_EVENT_MASK) ? {5'b00000, mask_reg} : 8'h00;

    // ------------------------------------------------------------
    // dma requests
    // ------------------------------------------------------------
    logic tx_req_next, rx_req_next;

    assign tx_req_next = cfg.tx_empty_dma_enable & tx_buffer_empty_flag;
    assign rx_req_next = cfg.rx_full_dma_enable & rx_buffer_full_flag;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_dma_req <= 1'b0;
            rx_dma_req <= 1'b0;
        end else begin
            tx_dma_req <= tx_req_next;
            rx_dma_req <= rx_req_next;
        end
    end

    // ------------------------------------------------------------
    // receive sampling and transmit bit rate
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_sample_en <= 1'b0;
            rx_realign <= 1'b0;
        end else begin
            rx_sample_en <= baud_rise_tick | (cfg.dual_edge_sampling & baud_fall_tick);
            rx_realign <= rx_one_zero_edge & ~cfg.midword_realign_disable;
        end
    end

    // transmitter steps once per full ratio of rising baud ticks
    usdc_tx_rate_div #(
        .CODE_W(5)
    ) u_tx_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .baud_tick(baud_rise_tick),
        .ratio_code(cfg.oversample_ratio),
        .bit_en(tx_bit_en)
    );

    // ------------------------------------------------------------
    // interrupt status, clear on read, set wins over clear
    // ------------------------------------------------------------
    assign events[EVT_TX_DMA] = tx_req_next & ~tx_dma_req;
    assign events[EVT_RX_DMA] = rx_req_next & ~rx_dma_req;
    assign events[EVT_OVS_FIX] = ovs_invalid;
    assign status_next = (rd_status ? '0 : status_reg) | events;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_reg <= '0;
            mask_reg <= '0;
            irq <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (wr_mask) begin
                mask_reg <= wr_data[EVT_W-1:0];
            end
            irq <= |(status_next & (wr_mask ? wr_data[EVT_W-1:0] : mask_reg));
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_ovs_write_bad;
        wr_char_ovs && (ovs_code_in < OVS_MIN_CODE);
    endsequence

    sequence s_ovs_write_good;
        wr_char_ovs && (ovs_code_in >= OVS_MIN_CODE);
    endsequence

    a_ten_bit_store: assert property (
        wr_char_ovs |=> cfg.ten_bit_char_select == $past(wr_data[BIT_TEN_BIT]))
        else $error("ten-bit select not stored");
    a_ovs_code_store: assert property (
        s_ovs_write_good |=> cfg.oversample_ratio == $past(ovs_code_in))
        else $error("valid oversample code not stored");
    a_ovs_bad_default: assert property (
        s_ovs_write_bad |=> cfg.oversample_ratio == OVS_DEFAULT_CODE ##0 status_reg[EVT_OVS_FIX])
        else $error("invalid oversample code not replaced by sixteen");
    a_tx_dma_follow: assert property (
        cfg.tx_empty_dma_enable && tx_buffer_empty_flag && !wr_dma_sample |=> tx_dma_req)
        else $error("tx dma request missing");
    a_rx_dma_follow: assert property (
        rx_dma_req == $past(cfg.rx_full_dma_enable && rx_buffer_full_flag))
        else $error("rx dma request wrong");
    a_dma_reserved_zero: assert property (
        rd_en && (rd_idx == IDX_DMA_SAMPLE_CTRL) |=> (s_axi_rdata[7:0] & 8'h5C) == 8'h00)
        else $error("reserved dma control bits not zero");
    a_rx_sample_edges: assert property (
        baud_fall_tick && !baud_rise_tick |=> rx_sample_en == $past(cfg.dual_edge_sampling))
        else $error("falling edge sample wrong");
    a_realign_gate: assert property (
        cfg.midword_realign_disable && !wr_dma_sample |=> !rx_realign)
        else $error("realign while disabled");
    a_tx_bit_tick: assert property (
        tx_bit_en |-> $past(baud_rise_tick))
        else $error("tx bit enable without baud tick");
    a_dma_drop: assert property (
        (!tx_buffer_empty_flag |=> !tx_dma_req) and (!rx_buffer_full_flag |=> !rx_dma_req))
        else $error("dma request held after flag clear");
endmodule
`default_nettype wire

/* include/usdc_pkg.sv */
package usdc_pkg;
    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [3:0] IDX_CHAR_OVS_CTRL = 4'hA;
    localparam logic [3:0] IDX_DMA_SAMPLE_CTRL = 4'hB;
    localparam logic [3:0] IDX_EVENT_STATUS = 4'hC;
    localparam logic [3:0] IDX_EVENT_MASK = 4'hD;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_TEN_BIT = 5;
    localparam int BIT_TX_DMA_EN = 7;
    localparam int BIT_RX_DMA_EN = 5;
    localparam int BIT_DUAL_EDGE = 1;
    localparam int BIT_REALIGN_DIS = 0;
    localparam logic [7:0] CHAR_OVS_RESET = 8'h0F;
    localparam logic [7:0] DMA_SAMPLE_RESET = 8'h00;
    localparam logic [4:0] OVS_MIN_CODE = 5'h03;
    localparam logic [4:0] OVS_DEFAULT_CODE = 5'h0F;

    // event status / mask bits
    localparam int EVT_W = 3;
    localparam int EVT_TX_DMA = 0;
    localparam int EVT_RX_DMA = 1;
    localparam int EVT_OVS_FIX = 2;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic ten_bit_char_select;
        logic [4:0] oversample_ratio;
        logic tx_empty_dma_enable;
        logic rx_full_dma_enable;
        logic dual_edge_sampling;
        logic midword_realign_disable;
    } usdc_cfg_t;

    function automatic logic usdc_idx_mapped(input logic [3:0] idx);
        return (idx >= IDX_CHAR_OVS_CTRL) && (idx <= IDX_EVENT_MASK);
    endfunction

    function automatic logic [4:0] usdc_ovs_fix(input logic [4:0] code);
        return (code < OVS_MIN_CODE) ? OVS_DEFAULT_CODE : code;
    endfunction
endpackage

/* hdl/usdc_axil_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module usdc_axil_slave
    import usdc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register side
    output logic wr_en,
    output logic [3:0] wr_idx,
    output logic [7:0] wr_data,
    output logic rd_en,
    output logic [3:0] rd_idx,
    input wire logic [7:0] rd_data
);
    logic [3:0] aw_idx_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg;
    logic aw_take, w_take, ar_take, commit;

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    // both halves held (ready low) and no response pending
    assign commit = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign wr_en = commit & w_lane0_reg & usdc_idx_mapped(aw_idx_reg);
    assign wr_idx = aw_idx_reg;
    assign wr_data = w_data_reg;
    assign rd_idx = s_axi_araddr[5:2];
    assign rd_en = ar_take & usdc_idx_mapped(rd_idx);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_idx_reg <= 4'h0;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end else begin
            if (aw_take) begin
                s_axi_awready <= 1'b0;
                aw_idx_reg <= s_axi_awaddr[5:2];
            end
            if (w_take) begin
                s_axi_wready <= 1'b0;
                w_data_reg <= s_axi_wdata[7:0];
                w_lane0_reg <= s_axi_wstrb[0];
            end
            if (commit) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= usdc_idx_mapped(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_data};
            s_axi_rresp <= usdc_idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* hdl/usdc_tx_rate_div.sv */
`timescale 1ns/1ps
`default_nettype none
module usdc_tx_rate_div #(
    parameter int CODE_W = 5
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // baud side
    input wire logic baud_tick,
    input wire logic [CODE_W-1:0] ratio_code,
    output logic bit_en
);
    logic [CODE_W-1:0] count_reg;
    logic wrap;

    // divide by code plus one, so the period equals the oversampling ratio
    assign wrap = (count_reg >= ratio_code);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
            bit_en <= 1'b0;
        end else begin
            bit_en <= baud_tick & wrap;
            if (baud_tick) begin
                count_reg <= wrap ? '0 : count_reg + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/usdc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module usdc_far_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bench commands
    input wire logic burst_go,
    input wire logic set_tx,
    input wire logic set_rx,
    input wire logic edge_go,
    input wire logic svc_slow,
    // requests from the block
    input wire logic tx_dma_req,
    input wire logic rx_dma_req,
    // flags, ticks and edges toward the block, burst status to the bench
    output logic tx_buffer_empty_flag,
    output logic rx_buffer_full_flag,
    output logic baud_rise_tick,
    output logic baud_fall_tick,
    output logic rx_one_zero_edge,
    output logic burst_busy
);
    logic [7:0] tick_cnt_reg;
    logic [3:0] tx_wait_reg;
    logic [3:0] rx_wait_reg;
    logic [3:0] svc_limit;

    // a burst is 32 rising ticks, each followed by a falling tick half a period later
    assign burst_busy = (tick_cnt_reg != 8'h00);
    assign baud_rise_tick = burst_busy && (tick_cnt_reg[1:0] == 2'h0);
    assign baud_fall_tick = burst_busy && (tick_cnt_reg[1:0] == 2'h2);
    // a slow dma side keeps the flag set for a while after the request appears
    assign svc_limit = svc_slow ? 4'hC : 4'h1;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 8'h00;
            tx_wait_reg <= 4'h0;
            rx_wait_reg <= 4'h0;
            tx_buffer_empty_flag <= 1'b0;
            rx_buffer_full_flag <= 1'b0;
            rx_one_zero_edge <= 1'b0;
        end else begin
            rx_one_zero_edge <= edge_go;
            if (burst_go) begin
                tick_cnt_reg <= 8'h80;
            end else if (burst_busy) begin
                tick_cnt_reg <= tick_cnt_reg - 8'h01;
            end
            // serving a request is the data access that clears the flag
            if (set_tx) begin
                tx_buffer_empty_flag <= 1'b1;
                tx_wait_reg <= 4'h0;
            end else if (tx_buffer_empty_flag && tx_dma_req) begin
                tx_wait_reg <= tx_wait_reg + 4'h1;
                tx_buffer_empty_flag <= (tx_wait_reg != svc_limit);
            end
            if (set_rx) begin
                rx_buffer_full_flag <= 1'b1;
                rx_wait_reg <= 4'h0;
            end else if (rx_buffer_full_flag && rx_dma_req) begin
                rx_wait_reg <= rx_wait_reg + 4'h1;
                rx_buffer_full_flag <= (rx_wait_reg != svc_limit);
            end
        end
    end
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import usdc_pkg::*;
;
    logic sys_clk, rst;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic tx_buffer_empty_flag, rx_buffer_full_flag, baud_rise_tick, baud_fall_tick;
    logic rx_one_zero_edge, rx_sample_en, tx_bit_en, rx_realign, tx_dma_req, rx_dma_req, irq;
    usdc_cfg_t cfg;
    logic burst_go, set_tx, set_rx, edge_go, svc_slow, burst_busy, cnt_clr;
    logic [7:0] sample_cnt, tx_cnt, realign_cnt;
    int bad_count, tests_run, cyc;

    usdc_config usdc_config_inst (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_buffer_empty_flag, .rx_buffer_full_flag,
        .baud_rise_tick, .baud_fall_tick, .rx_one_zero_edge, .cfg, .rx_sample_en, .tx_bit_en,
        .rx_realign, .tx_dma_req, .rx_dma_req, .irq);
    usdc_far_model usdc_far_model_inst (.sys_clk, .rst, .burst_go, .set_tx, .set_rx, .edge_go,
        .svc_slow, .tx_dma_req, .rx_dma_req, .tx_buffer_empty_flag, .rx_buffer_full_flag,
        .baud_rise_tick, .baud_fall_tick, .rx_one_zero_edge, .burst_busy);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // counters and shared tasks
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cnt_clr) begin
            sample_cnt <= 8'h00;
            tx_cnt <= 8'h00;
            realign_cnt <= 8'h00;
        end else begin
            sample_cnt <= sample_cnt + {7'h00, rx_sample_en};
            tx_cnt <= tx_cnt + {7'h00, tx_bit_en};
            realign_cnt <= realign_cnt + {7'h00, rx_realign};
        end
        // every scenario together needs under a thousand cycles
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic wr_chk(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (!s_axi_bvalid);
        chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd_chk(input string n, input logic [3:0] idx, input logic [7:0] e,
        input logic [1:0] er);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        chk(n, {24'h0, e}, s_axi_rdata);
        chk("read response", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk("cfg at reset", 32'h0F0, {22'h0, cfg});
        chk("requests at reset", 32'h0, {29'h0, irq, tx_dma_req, rx_dma_req});
        rd_chk("char ratio reset", IDX_CHAR_OVS_CTRL, CHAR_OVS_RESET, RESP_OKAY);
        rd_chk("dma ctrl reset", IDX_DMA_SAMPLE_CTRL, 8'h00, RESP_OKAY);
        wr_chk(4'h0, 8'h5A, RESP_SLVERR);
        rd_chk("unmapped read", 4'hF, 8'h00, RESP_SLVERR);
        wr_chk(IDX_DMA_SAMPLE_CTRL, 8'hFF, RESP_OKAY);
        rd_chk("dma ctrl reserved", IDX_DMA_SAMPLE_CTRL, 8'hA3, RESP_OKAY);
        chk("cfg control bits", 32'hF, {28'h0, cfg[3:0]});
        wr_chk(IDX_DMA_SAMPLE_CTRL, 8'h00, RESP_OKAY);
    endtask

    task automatic t_ovs();
        logic [4:0] code;
        logic [7:0] e;
        for (int k = 0; k < 32; k++) begin
            code = k[4:0];
            e = {2'b00, k[0], (code < 5'h03) ? 5'h0F : code};
            wr_chk(IDX_CHAR_OVS_CTRL, {2'b11, k[0], code}, RESP_OKAY);
            rd_chk("ratio readback", IDX_CHAR_OVS_CTRL, e, RESP_OKAY);
            chk("cfg char and ratio", {26'h0, e[5:0]}, {26'h0, cfg[9:4]});
        end
    endtask

    task automatic t_irq();
        wr_chk(IDX_EVENT_MASK, 8'h00, RESP_OKAY);
        rd_chk("status after bad codes", IDX_EVENT_STATUS, 8'h04, RESP_OKAY);
        wr_chk(IDX_CHAR_OVS_CTRL, 8'h01, RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr_chk(IDX_EVENT_MASK, 8'h04, RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        rd_chk("status pending", IDX_EVENT_STATUS, 8'h04, RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        chk("irq after clear", 32'h0, {31'h0, irq});
        wr_chk(IDX_EVENT_MASK, 8'h00, RESP_OKAY);
    endtask

    task automatic t_dma(input logic tx);
        logic seen;
        int i;
        seen = 1'b0;
        svc_slow <= tx;
        set_tx <= tx;
        set_rx <= !tx;
        @(posedge sys_clk);
        set_tx <= 1'b0;
        set_rx <= 1'b0;
        repeat (6) begin
            @(posedge sys_clk);
            seen = seen | (tx ? tx_dma_req : rx_dma_req);
        end
        chk("dma req while disabled", 32'h0, {31'h0, seen});
        wr_chk(IDX_DMA_SAMPLE_CTRL, tx ? 8'h80 : 8'h20, RESP_OKAY);
        for (i = 0; i < 8 && !(tx ? tx_dma_req : rx_dma_req); i++) @(posedge sys_clk);
        chk("dma req raised", 32'h1, {31'h0, tx ? tx_dma_req : rx_dma_req});
        if (tx) begin
            repeat (6) @(posedge sys_clk);
            chk("dma req held", 32'h1, {31'h0, tx_dma_req});
        end
        for (i = 0; i < 20 && (tx ? tx_buffer_empty_flag : rx_buffer_full_flag); i++) begin
            @(posedge sys_clk);
        end
        @(posedge sys_clk);
        chk("dma req dropped", 32'h0, {31'h0, tx ? tx_dma_req : rx_dma_req});
        rd_chk("dma event", IDX_EVENT_STATUS, tx ? 8'h01 : 8'h02, RESP_OKAY);
        wr_chk(IDX_DMA_SAMPLE_CTRL, 8'h00, RESP_OKAY);
    endtask

    // ticks only run in bursts, so the settings always change with the line idle
    task automatic t_rate(input logic [4:0] code, input logic dual);
        wr_chk(IDX_CHAR_OVS_CTRL, {3'b000, code}, RESP_OKAY);
        wr_chk(IDX_DMA_SAMPLE_CTRL, {6'h00, dual, 1'b0}, RESP_OKAY);
        cnt_clr <= 1'b1;
        burst_go <= 1'b1;
        @(posedge sys_clk);
        cnt_clr <= 1'b0;
        burst_go <= 1'b0;
        do @(posedge sys_clk); while (burst_busy);
        repeat (3) @(posedge sys_clk);
        chk("rx sample enables", dual ? 32'd64 : 32'd32, {24'h0, sample_cnt});
        chk("tx bit enables", 32 / (int'(code) + 1), {24'h0, tx_cnt});
    endtask

    task automatic t_realign();
        for (int d = 0; d < 2; d++) begin
            wr_chk(IDX_DMA_SAMPLE_CTRL, {7'h00, d[0]}, RESP_OKAY);
            cnt_clr <= 1'b1;
            edge_go <= 1'b1;
            @(posedge sys_clk);
            cnt_clr <= 1'b0;
            edge_go <= 1'b0;
            repeat (4) @(posedge sys_clk);
            chk("realign pulses", {31'h0, !d[0]}, {24'h0, realign_cnt});
        end
    endtask

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, burst_go, set_tx, set_rx} = 6'h00;
        {edge_go, svc_slow, cnt_clr} = 3'h0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        {sample_cnt, tx_cnt, realign_cnt} = 24'h000000;
        bad_count = 0;
        tests_run = 0;
        cyc = 0;
        rst = 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_ovs();
        t_irq();
        t_dma(1'b1);
        t_dma(1'b0);
        t_rate(5'h03, 1'b1);
        t_rate(5'h07, 1'b1);
        t_rate(5'h0F, 1'b0);
        t_rate(5'h1F, 1'b0);
        t_realign();
        end_of_test();
    end
endmodule
`default_nettype wire
